// >>> inc/csp_consts.svh
// Register offsets, field positions, reset values and counts of the clock and power block
// Function
// - System clock runs at half the source
// - Source from cpu mode and control bit
// - Reset selects main oscillator divided by two
// - Select bit seven picks undivided main
// - Amplifier off bits for external clocks
// - Synth reference select bit, main default
// - Prescaler divides by 2(n+1), 255 bypasses
// - VCO is prescaled reference times 2(n+1)
// - Divider 2(m+1), 255 stops synth clock
// - USB clock is VCO, tri-stated when off
// - Synth disabled holds VCO static
// - Lock flag once both clocks correct
// - Stop loads wake timers, resets mode
// - Stop released by reset or interrupt
// - Resume only after timer two underflow
// - Service waking interrupt, then resume state
// - Wait halts processor clock only
// - Reset release counts cascaded wake timers
// - Start address from two vector bytes
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH
`define CSP_OFF_CLKSEL 8'h00
`define CSP_OFF_CPUMODE 8'h04
`define CSP_OFF_AMP 8'h08
`define CSP_OFF_SYNCTL 8'h0c
`define CSP_OFF_VCOMUL 8'h10
`define CSP_OFF_PRESC 8'h14
`define CSP_OFF_OUTDIV 8'h18
`define CSP_OFF_USBCTL 8'h1c
`define CSP_OFF_STATUS 8'h20
`define CSP_OFF_START 8'h24
`define CSP_BIT_HF 7
`define CSP_BIT_MODE6 6
`define CSP_BIT_MODE7 7
`define CSP_BIT_MAIN_OFF 6
`define CSP_BIT_SUB_OFF 7
`define CSP_BIT_SYN_EN 0
`define CSP_BIT_SYN_REF 3
`define CSP_BIT_SYN_LOCK 6
`define CSP_BIT_USB_EN 5
`define CSP_RST_REG 8'h00
`define CSP_RST_VCOMUL 8'h00
`define CSP_RST_PRESC 8'hff
`define CSP_RST_OUTDIV 8'hff
`define CSP_DIV_OFF 8'hff
`define CSP_T1_LOAD 8'hff
`define CSP_T2_LOAD 8'h01
`define CSP_PHI_DIV_LAST 3'h7
`define CSP_VEC_HI 16'hfffa
`define CSP_VEC_LO 16'hfffb
`define CSP_LOCK_GOOD 2'h2
`endif

// >>> inc/csp_pkg.sv
// Types and helper function of the clock, synthesizer and power block
package csp_pkg;
  typedef enum logic [1:0] {
    CSP_SRC_MAIN_DIV2,
    CSP_SRC_MAIN,
    CSP_SRC_SUB,
    CSP_SRC_SYN
  } csp_src_t;
  typedef enum logic [2:0] {
    CSP_PW_RST_DLY,
    CSP_PW_VEC_HI,
    CSP_PW_VEC_LO,
    CSP_PW_VEC_END,
    CSP_PW_RUN,
    CSP_PW_STOP,
    CSP_PW_STOP_WAKE,
    CSP_PW_WAIT
  } csp_pwr_t;
  // Last count of a divide by 2(n+1) counter
  function automatic logic [8:0] csp_div_last(input logic [7:0] n);
    return {n, 1'b1};
  endfunction
endpackage

// >>> inc/csp_synth_if.sv
// Signals between the clock selector and the frequency synthesizer
`timescale 1ns/100ps
interface csp_synth_if;
  logic ref_tick;
  logic enable;
  logic [7:0] mult;
  logic [7:0] presc;
  logic [7:0] odiv;
  logic vco_tick;
  logic vco_level;
  logic syn_tick;
  logic lock;
  modport synth(input ref_tick, enable, mult, presc, odiv,
    output vco_tick, vco_level, syn_tick, lock);
  modport ctrl(output ref_tick, enable, mult, presc, odiv,
    input vco_tick, vco_level, syn_tick, lock);
endinterface

// >>> hw/csp_synth.sv
// Frequency synthesizer: prescaler, frequency locked VCO, output divider, lock flag
`timescale 1ns/100ps
`include "csp_consts.svh"
module csp_synth
  import csp_pkg::*;
#(
  parameter int PER_W = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Selector side
  csp_synth_if.synth sif
);
  logic [8:0] pcnt;
  logic pin_tick;
  logic [PER_W-1:0] per;
  logic [PER_W-1:0] vcnt;
  logic [9:0] hcnt;
  logic [9:0] target;
  logic [1:0] good;
  logic [8:0] dcnt;

  if (PER_W < 4 || PER_W > 16)
  begin : g_chk
    $error("csp_synth: PER_W must be 4 to 16");
  end

  assign target = {1'b0, csp_div_last(sif.mult)} + 10'h001;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pcnt <= 9'h000;
      pin_tick <= 1'b0;
    end
    else if (ce)
    begin
      pin_tick <= 1'b0;
      if (!sif.enable)
        pcnt <= 9'h000;
      else if (sif.ref_tick)
      begin
        if (sif.presc == `CSP_DIV_OFF)
          pin_tick <= 1'b1;
        else if (pcnt == csp_div_last(sif.presc))
        begin
          pcnt <= 9'h000;
          pin_tick <= 1'b1;
        end
        else
          pcnt <= pcnt + 9'h001;
      end
    end
  end

  // VCO: one tick per period, level high for the first half
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      vcnt <= '0;
      sif.vco_tick <= 1'b0;
      sif.vco_level <= 1'b0;
    end
    else if (ce)
    begin
      if (!sif.enable)
      begin
        vcnt <= '0;
        sif.vco_tick <= 1'b0;
        sif.vco_level <= 1'b0;
      end
      else
      begin
        sif.vco_level <= (vcnt < (per >> 1));
        if (vcnt >= per)
        begin
          vcnt <= '0;
          sif.vco_tick <= 1'b1;
        end
        else
        begin
          vcnt <= vcnt + 1'b1;
          sif.vco_tick <= 1'b0;
        end
      end
    end
  end

  // Loop: count VCO periods per prescaled period and trim the VCO period
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      per <= '1;
      hcnt <= 10'h000;
      good <= 2'h0;
    end
    else if (ce)
    begin
      if (!sif.enable)
      begin
        per <= '1;
        hcnt <= 10'h000;
        good <= 2'h0;
      end
      else if (pin_tick)
      begin
        hcnt <= 10'h000;
        if (hcnt < target)
        begin
          if (per != 1) per <= per - 1'b1;
          good <= 2'h0;
        end
        else if (hcnt > target)
        begin
          if (per != '1) per <= per + 1'b1;
          good <= 2'h0;
        end
        else if (good != 2'h3)
          good <= good + 2'h1;
      end
      else if (sif.vco_tick && hcnt != 10'h3ff)
        hcnt <= hcnt + 10'h001;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      dcnt <= 9'h000;
      sif.syn_tick <= 1'b0;
    end
    else if (ce)
    begin
      sif.syn_tick <= 1'b0;
      if (!sif.enable || sif.odiv == `CSP_DIV_OFF)
        dcnt <= 9'h000;
      else if (sif.vco_tick)
      begin
        if (dcnt == csp_div_last(sif.odiv))
        begin
          dcnt <= 9'h000;
          sif.syn_tick <= 1'b1;
        end
        else
          dcnt <= dcnt + 9'h001;
      end
    end
  end

  // Synth clock is derived from the VCO, so one locked VCO means both are right
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      sif.lock <= 1'b0;
    else if (ce)
      sif.lock <= sif.enable && good >= `CSP_LOCK_GOOD;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_presc_count: assert property (
    (ce && pin_tick && sif.presc != `CSP_DIV_OFF) |-> pcnt == 9'h000
  ) else $error("prescaler tick without full count");

  chk_vco_static: assert property (
    (ce && !sif.enable) |=> !sif.vco_tick && !sif.vco_level
  ) else $error("VCO moves while synth disabled");

  chk_div_off: assert property (
    (sif.odiv == `CSP_DIV_OFF && $past(sif.odiv) == `CSP_DIV_OFF) |-> !sif.syn_tick
  ) else $error("synth clock runs with divider off");

  chk_lock_off: assert property (
    (ce && !sif.enable) |=> !sif.lock
  ) else $error("lock flag set while synth disabled");
endmodule // csp_synth

// >>> hw/csp_top.sv
// Clock source selection, synthesizer control, stop and wait modes, reset start-up
`timescale 1ns/100ps
`include "csp_consts.svh"
module csp_top
  import csp_pkg::*;
#(
  parameter int PER_W = 8
)
(
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator pins
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  output logic main_amp_en,
  output logic sub_amp_en,
  // Generated clocks
  output logic sys_phi1,
  output logic sys_phi2,
  output logic cpu_clk_en,
  output logic usb_clk_out,
  output logic usb_clk_oe,
  // Processor and interrupt side
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic ext_irq_in,
  input wire logic ext_irq_enable,
  input wire logic irq_disable_flag,
  input wire logic periph_irq,
  output logic wake_service,
  output logic timer_mode_reset,
  // Reset vector fetch
  output logic vec_rd,
  output logic [15:0] vec_addr,
  input wire logic [7:0] vec_data,
  output logic start_valid,
  output logic [15:0] start_addr
);
  logic [7:0] clock_select_register;
  logic [7:0] cpu_mode;
  logic [7:0] amp_ctrl;
  logic [7:0] synth_control_register;
  logic [7:0] vco_multiplier;
  logic [7:0] ref_prescaler;
  logic [7:0] output_divider;
  logic [7:0] usb_ctrl;
  logic [2:0] main_s;
  logic [2:0] sub_s;
  logic [1:0] ext_s;
  logic main_tick;
  logic sub_tick;
  logic half;
  logic osc_stopped;
  csp_src_t req_src;
  csp_src_t cur_src;
  csp_src_t tgt_src;
  logic sw_busy;
  logic cur_tick;
  logic ph;
  logic phi_tick;
  logic [2:0] pdiv;
  logic t_tick;
  logic t_under;
  logic [7:0] t1;
  logic [7:0] t2;
  csp_pwr_t pwr;
  logic ext_wake;
  logic [7:0] vec_hi;
  logic apb_wr;
  logic src_moved;

  csp_synth_if sif();

  if (PER_W < 4 || PER_W > 16)
  begin : g_chk
    $error("csp_top: PER_W must be 4 to 16");
  end

  function automatic logic addr_mapped(input logic [7:0] a);
    return a <= `CSP_OFF_START && a[1:0] == 2'b00;
  endfunction

  // Tick of a given source; main divided by two uses every other main edge
  function automatic logic src_tick(input csp_src_t s);
    case (s)
      CSP_SRC_MAIN_DIV2: return main_tick && half;
      CSP_SRC_MAIN: return main_tick;
      CSP_SRC_SUB: return sub_tick;
      CSP_SRC_SYN: return sif.syn_tick;
      default: return 1'b0;
    endcase
  endfunction

  // APB: zero wait, read data loaded in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign apb_wr = psel && penable && pwrite && addr_mapped(paddr);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_select_register <= `CSP_RST_REG;
      cpu_mode <= `CSP_RST_REG;
      amp_ctrl <= `CSP_RST_REG;
      synth_control_register <= `CSP_RST_REG;
      vco_multiplier <= `CSP_RST_VCOMUL;
      ref_prescaler <= `CSP_RST_PRESC;
      output_divider <= `CSP_RST_OUTDIV;
      usb_ctrl <= `CSP_RST_REG;
    end
    else if (ce && apb_wr)
    begin
      case (paddr)
        `CSP_OFF_CLKSEL: clock_select_register <= pwdata[7:0];
        `CSP_OFF_CPUMODE: cpu_mode <= pwdata[7:0];
        `CSP_OFF_AMP: amp_ctrl <= pwdata[7:0];
        `CSP_OFF_SYNCTL: synth_control_register <= pwdata[7:0];
        `CSP_OFF_VCOMUL: vco_multiplier <= pwdata[7:0];
        `CSP_OFF_PRESC: ref_prescaler <= pwdata[7:0];
        `CSP_OFF_OUTDIV: output_divider <= pwdata[7:0];
        `CSP_OFF_USBCTL: usb_ctrl <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      prdata <= 32'h0000_0000;
    else if (ce && psel && !penable && !pwrite)
    begin
      case (paddr)
        `CSP_OFF_CLKSEL: prdata <= {24'h00_0000, clock_select_register};
        `CSP_OFF_CPUMODE: prdata <= {24'h00_0000, cpu_mode};
        `CSP_OFF_AMP: prdata <= {24'h00_0000, amp_ctrl};
        `CSP_OFF_SYNCTL: prdata <= {24'h00_0000, synth_control_register[7],
          sif.lock, synth_control_register[5:0]};
        `CSP_OFF_VCOMUL: prdata <= {24'h00_0000, vco_multiplier};
        `CSP_OFF_PRESC: prdata <= {24'h00_0000, ref_prescaler};
        `CSP_OFF_OUTDIV: prdata <= {24'h00_0000, output_divider};
        `CSP_OFF_USBCTL: prdata <= {24'h00_0000, usb_ctrl};
        `CSP_OFF_STATUS: prdata <= {t2, t1, 5'h00, 3'(pwr), 3'h0, sw_busy,
          2'(cur_src), 1'b0, sif.lock};
        `CSP_OFF_START: prdata <= {16'h0000, start_addr};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Pin synchronisers; the third stage only serves edge detection
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      main_s <= 3'h0;
      sub_s <= 3'h0;
      ext_s <= 2'h0;
    end
    else if (ce)
    begin
      main_s <= {main_s[1:0], main_osc_in};
      sub_s <= {sub_s[1:0], sub_osc_in};
      ext_s <= {ext_s[0], ext_irq_in};
    end
  end

  // Stopped oscillators deliver no edges even if the pin still toggles
  assign main_tick = main_s[1] && !main_s[2] && !osc_stopped;
  assign sub_tick = sub_s[1] && !sub_s[2] && !osc_stopped;
  assign ext_wake = ext_s[1] && ext_irq_enable && !irq_disable_flag;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      half <= 1'b0;
    else if (ce && main_tick)
      half <= !half;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      main_amp_en <= 1'b1;
      sub_amp_en <= 1'b1;
    end
    else if (ce)
    begin
      main_amp_en <= !amp_ctrl[`CSP_BIT_MAIN_OFF] && !osc_stopped;
      sub_amp_en <= !amp_ctrl[`CSP_BIT_SUB_OFF] && !osc_stopped;
    end
  end

  // Synthesizer reference and controls
  assign sif.ref_tick = synth_control_register[`CSP_BIT_SYN_REF] ? sub_tick : main_tick;
  assign sif.enable = synth_control_register[`CSP_BIT_SYN_EN];
  assign sif.mult = vco_multiplier;
  assign sif.presc = ref_prescaler;
  assign sif.odiv = output_divider;

  csp_synth #(.PER_W(PER_W)) u_synth (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .sif(sif)
  );

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      usb_clk_out <= 1'b0;
      usb_clk_oe <= 1'b0;
    end
    else if (ce)
    begin
      usb_clk_out <= sif.vco_level;
      usb_clk_oe <= usb_ctrl[`CSP_BIT_USB_EN];
    end
  end

  always_comb
  begin
    case ({cpu_mode[`CSP_BIT_MODE7], cpu_mode[`CSP_BIT_MODE6]})
      2'b00: req_src = clock_select_register[`CSP_BIT_HF] ? CSP_SRC_MAIN
        : CSP_SRC_MAIN_DIV2;
      2'b01: req_src = CSP_SRC_SUB;
      default: req_src = CSP_SRC_SYN;
    endcase
  end

  // Switch only after an old edge, then wait for a new edge; clocks idle between
  // The function reads module signals, which only a combinational process follows
  always_comb
  begin
    cur_tick = src_tick(cur_src);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_src <= CSP_SRC_MAIN_DIV2;
      tgt_src <= CSP_SRC_MAIN_DIV2;
      sw_busy <= 1'b0;
    end
    else if (ce)
    begin
      if (!sw_busy)
      begin
        if (req_src != cur_src && cur_tick)
        begin
          sw_busy <= 1'b1;
          tgt_src <= req_src;
        end
      end
      else if (src_tick(tgt_src))
      begin
        cur_src <= tgt_src;
        sw_busy <= 1'b0;
      end
    end
  end

  // Phase flips on each source edge; both phases low in the edge cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph <= 1'b0;
      sys_phi1 <= 1'b0;
      sys_phi2 <= 1'b0;
    end
    else if (ce)
    begin
      if (sw_busy)
      begin
        sys_phi1 <= 1'b0;
        sys_phi2 <= 1'b0;
      end
      else if (cur_tick)
      begin
        ph <= !ph;
        sys_phi1 <= 1'b0;
        sys_phi2 <= 1'b0;
      end
      else
      begin
        sys_phi1 <= ph;
        sys_phi2 <= !ph;
      end
    end
  end

  assign phi_tick = cur_tick && !sw_busy && !ph;
  assign t_tick = phi_tick && pdiv == `CSP_PHI_DIV_LAST;
  assign t_under = t_tick && t1 == 8'h00 && t2 == 8'h00;

  // Wake timers count system clock divided by eight
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      pdiv <= 3'h0;
    else if (ce)
    begin
      if (pwr != CSP_PW_RST_DLY && pwr != CSP_PW_STOP_WAKE)
        pdiv <= 3'h0;
      else if (phi_tick)
        pdiv <= pdiv + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      t1 <= `CSP_T1_LOAD;
      t2 <= `CSP_T2_LOAD;
    end
    else if (ce)
    begin
      if (pwr == CSP_PW_RUN && stop_instruction)
      begin
        t1 <= `CSP_T1_LOAD;
        t2 <= `CSP_T2_LOAD;
      end
      else if ((pwr == CSP_PW_RST_DLY || pwr == CSP_PW_STOP_WAKE) && t_tick)
      begin
        if (t1 == 8'h00)
        begin
          t1 <= `CSP_T1_LOAD;
          t2 <= t2 - 8'h01;
        end
        else
          t1 <= t1 - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwr <= CSP_PW_RST_DLY;
      osc_stopped <= 1'b0;
      wake_service <= 1'b0;
      timer_mode_reset <= 1'b0;
      cpu_clk_en <= 1'b0;
      vec_rd <= 1'b0;
      vec_addr <= 16'h0000;
      vec_hi <= 8'h00;
      start_valid <= 1'b0;
      start_addr <= 16'h0000;
    end
    else if (ce)
    begin
      wake_service <= 1'b0;
      timer_mode_reset <= 1'b0;
      start_valid <= 1'b0;
      case (pwr)
        CSP_PW_RST_DLY:
          if (t_under)
          begin
            pwr <= CSP_PW_VEC_HI;
            vec_rd <= 1'b1;
            vec_addr <= `CSP_VEC_HI;
          end
        CSP_PW_VEC_HI:
        begin
          pwr <= CSP_PW_VEC_LO;
          vec_addr <= `CSP_VEC_LO;
        end
        CSP_PW_VEC_LO:
        begin
          pwr <= CSP_PW_VEC_END;
          vec_rd <= 1'b0;
          vec_hi <= vec_data;
        end
        CSP_PW_VEC_END:
        begin
          pwr <= CSP_PW_RUN;
          start_addr <= {vec_hi, vec_data};
          start_valid <= 1'b1;
          cpu_clk_en <= 1'b1;
        end
        CSP_PW_RUN:
          if (stop_instruction)
          begin
            pwr <= CSP_PW_STOP;
            osc_stopped <= 1'b1;
            timer_mode_reset <= 1'b1;
            cpu_clk_en <= 1'b0;
          end
          else if (wait_instruction)
          begin
            pwr <= CSP_PW_WAIT;
            cpu_clk_en <= 1'b0;
          end
        CSP_PW_STOP:
          if (ext_wake)
          begin
            pwr <= CSP_PW_STOP_WAKE;
            osc_stopped <= 1'b0;
          end
        CSP_PW_STOP_WAKE:
          if (t_under)
          begin
            pwr <= CSP_PW_RUN;
            wake_service <= 1'b1;
            cpu_clk_en <= 1'b1;
          end
        CSP_PW_WAIT:
          if (periph_irq || ext_wake)
          begin
            pwr <= CSP_PW_RUN;
            wake_service <= 1'b1;
            cpu_clk_en <= 1'b1;
          end
        default:
          pwr <= CSP_PW_RUN;
      endcase
    end
  end

  // Set once software has asked for anything but the reset source
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      src_moved <= 1'b0;
    else if (req_src != CSP_SRC_MAIN_DIV2)
      src_moved <= 1'b1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_phi_nonoverlap: assert property (
    !(sys_phi1 && sys_phi2)
  ) else $error("system clock phases overlap");

  chk_reset_div2: assert property (
    !src_moved |-> cur_src == CSP_SRC_MAIN_DIV2 && !sw_busy
  ) else $error("source left main divided by two without request");

  chk_switch_dead: assert property (
    (ce && sw_busy) |=> !sys_phi1 && !sys_phi2
  ) else $error("phase output during source switch");

  chk_hf_switch: assert property (
    (ce && !sw_busy && cur_tick && req_src == CSP_SRC_MAIN && cur_src != CSP_SRC_MAIN)
      |=> sw_busy && tgt_src == CSP_SRC_MAIN
  ) else $error("high frequency request not taken");

  chk_amp_off: assert property (
    (ce && amp_ctrl[`CSP_BIT_MAIN_OFF]) |=> !main_amp_en
  ) else $error("main amplifier on while disabled");

  chk_usb_tristate: assert property (
    (ce && !usb_ctrl[`CSP_BIT_USB_EN]) |=> !usb_clk_oe
  ) else $error("USB clock driven while disabled");

  chk_stop_hold: assert property (
    (ce && pwr == CSP_PW_STOP && !ext_wake) |=> pwr == CSP_PW_STOP && main_amp_en == 1'b0
  ) else $error("stop left without wake event");

  chk_wake_cause: assert property (
    $rose(wake_service) |-> $past(pwr) == CSP_PW_STOP_WAKE || $past(pwr) == CSP_PW_WAIT
  ) else $error("wake service without wake path");

  chk_wait_cpu: assert property (
    pwr == CSP_PW_WAIT |-> !cpu_clk_en
  ) else $error("processor clock runs in wait");

  chk_vec_order: assert property (
    (ce && pwr == CSP_PW_VEC_HI) |-> vec_rd && vec_addr == `CSP_VEC_HI
      ##1 (ce && pwr == CSP_PW_VEC_LO) |-> vec_rd && vec_addr == `CSP_VEC_LO
  ) else $error("reset vector fetch out of order");
endmodule // csp_top

// >>> tb/csp_osc_model.sv
// Oscillator pins model: crystals that rest once their amplifier is off
`timescale 1ns/100ps
module csp_osc_model
(
  // Amplifier enables
  input wire logic main_amp_en,
  input wire logic sub_amp_en,
  // Oscillator levels
  output logic main_osc_in,
  output logic sub_osc_in
);
  // A crystal without gain stops at rest, so edges cease rather than freeze high
  initial
  begin
    main_osc_in = 1'b0;
    sub_osc_in = 1'b0;
    #7;
    fork
      forever #40 main_osc_in = main_amp_en & ~main_osc_in;
      forever #110 sub_osc_in = sub_amp_en & ~sub_osc_in;
    join
  end
endmodule // csp_osc_model

// >>> tb/tb_clock_synth_power_reset.sv
// Self-checking bench of source selection, wait mode and reset start-up
`timescale 1ns/100ps
`include "csp_consts.svh"
module tb_clock_synth_power_reset;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic main_osc_in, sub_osc_in, main_amp_en, sub_amp_en;
  logic sys_phi1, sys_phi2, cpu_clk_en, usb_clk_out, usb_clk_oe;
  logic wait_instruction = 1'b0, periph_irq = 1'b0, wake_service, timer_mode_reset;
  logic stop_instruction = 1'b0, ext_irq_in = 1'b0, ext_irq_enable = 1'b0;
  logic vec_rd, start_valid;
  logic [15:0] vec_addr, start_addr;
  logic [7:0] vec_data = 8'h00;
  int failures = 0, n_checks = 0, cycles = 0, i;

  csp_top dut (.mclk(mclk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in),
    .main_amp_en(main_amp_en), .sub_amp_en(sub_amp_en), .sys_phi1(sys_phi1),
    .sys_phi2(sys_phi2), .cpu_clk_en(cpu_clk_en), .usb_clk_out(usb_clk_out),
    .usb_clk_oe(usb_clk_oe), .stop_instruction(stop_instruction),
    .wait_instruction(wait_instruction), .ext_irq_in(ext_irq_in),
    .ext_irq_enable(ext_irq_enable), .irq_disable_flag(1'b0),
    .periph_irq(periph_irq), .wake_service(wake_service), .timer_mode_reset(timer_mode_reset),
    .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_data(vec_data), .start_valid(start_valid),
    .start_addr(start_addr));

  csp_osc_model osc (.main_amp_en(main_amp_en), .sub_amp_en(sub_amp_en),
    .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in));

  always #20 mclk = ~mclk;

  // Vector memory answers a cycle after the address; scrambled when not read
  always @(posedge mclk)
    vec_data <= vec_rd ? (vec_addr[0] ? 8'hc3 : 8'h5a) : ~vec_data;

  // Reset delay and stop wake-up take some 33k cycles each
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 99000)
    begin
      failures = failures + 1;
      stop_test();
    end
  end

  task stop_test();
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("register", exp, rd & mask);
  endtask

  task src_is(input logic [1:0] exp);
    i = 0;
    do
    begin
      xfer(1'b0, `CSP_OFF_STATUS, 32'h0);
      i++;
    end
    while (rd[3:2] !== exp && i < 100);
    chk("cur_src", {30'h0, exp}, {30'h0, rd[3:2]});
  endtask

  // Counts phase-one rises over 400 cycles, allowing for sync jitter
  task phi_rate(input int exp);
    int n;
    logic p;
    n = 0;
    p = sys_phi1;
    repeat (400)
    begin
      @(posedge mclk);
      #1;
      n += (sys_phi1 === 1'b1 && p === 1'b0);
      p = sys_phi1;
    end
    chk("phi1 rises", exp, n > exp - 3 && n < exp + 3 ? exp : n);
  endtask

  // Sub reference halved gives a steady 11-cycle window, so the loop settles
  task synth_run();
    xfer(1'b1, `CSP_OFF_PRESC, 32'h0);
    xfer(1'b1, `CSP_OFF_VCOMUL, 32'h0);
    xfer(1'b1, `CSP_OFF_OUTDIV, 32'h0);
    xfer(1'b1, `CSP_OFF_SYNCTL, 32'h9);
    i = 0;
    do
    begin
      xfer(1'b0, `CSP_OFF_SYNCTL, 32'h0);
      i++;
    end
    while (rd[6] !== 1'b1 && i < 2000);
    chk("synth_lock_flag", 1, rd[6]);
    i = 0;
    repeat (20)
    begin
      @(posedge mclk);
      i += (usb_clk_out === 1'b1);
    end
    chk("usb_clk_out", 1, i > 3 && i < 13);
    xfer(1'b1, `CSP_OFF_CPUMODE, 32'h80);
    src_is(2'h3);
    xfer(1'b1, `CSP_OFF_CPUMODE, 32'h0);
    src_is(2'h0);
    xfer(1'b1, `CSP_OFF_SYNCTL, 32'h8);
    rd_chk(`CSP_OFF_SYNCTL, 32'h49, 32'h8);
  endtask

  // Stop halts both crystals; an enabled external interrupt restarts them
  task stop_run();
    @(posedge mclk);
    stop_instruction <= 1'b1;
    @(posedge mclk);
    stop_instruction <= 1'b0;
    #1;
    chk("timer_mode_reset", 1, timer_mode_reset);
    repeat (50) @(posedge mclk);
    rd_chk(`CSP_OFF_STATUS, 32'hffff0700, 32'h01ff0500);
    chk("amps", 0, {main_amp_en, sub_amp_en});
    ext_irq_enable <= 1'b1;
    ext_irq_in <= 1'b1;
    for (i = 0; i < 40000 && wake_service !== 1'b1; i++)
      @(posedge mclk);
    chk("stop wake", 1, i > 30000 && i < 33000);
    chk("cpu_clk_en", 1, cpu_clk_en);
    ext_irq_in <= 1'b0;
    ext_irq_enable <= 1'b0;
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(`CSP_OFF_PRESC, 32'hff, 32'hff);
    rd_chk(`CSP_OFF_OUTDIV, 32'hff, 32'hff);
    rd_chk(`CSP_OFF_VCOMUL, 32'hff, 32'h0);
    rd_chk(`CSP_OFF_SYNCTL, 32'h49, 32'h0);
    src_is(2'h0);
    for (i = 0; i < 90000 && start_valid !== 1'b1; i++)
      @(posedge mclk);
    chk("reset delay", 1, i > 30000 && i < 33000);
    chk("start_addr", 16'h5ac3, start_addr);
    phi_rate(50);
    xfer(1'b1, `CSP_OFF_CLKSEL, 32'h80);
    src_is(2'h1);
    phi_rate(100);
    xfer(1'b1, `CSP_OFF_CPUMODE, 32'h40);
    src_is(2'h2);
    xfer(1'b1, `CSP_OFF_CPUMODE, 32'h0);
    xfer(1'b1, `CSP_OFF_CLKSEL, 32'h0);
    src_is(2'h0);
    xfer(1'b1, `CSP_OFF_AMP, 32'hc0);
    repeat (2) @(posedge mclk);
    chk("amps", 0, {main_amp_en, sub_amp_en});
    xfer(1'b1, `CSP_OFF_AMP, 32'h0);
    xfer(1'b1, `CSP_OFF_USBCTL, 32'h20);
    repeat (2) @(posedge mclk);
    chk("usb_clk_oe", 1, usb_clk_oe);
    xfer(1'b1, `CSP_OFF_USBCTL, 32'h0);
    repeat (2) @(posedge mclk);
    chk("usb_clk_oe", 0, usb_clk_oe);
    xfer(1'b0, 8'h28, 32'h0);
    chk("pslverr", 1, err);
    chk("unmapped", 0, rd);
    synth_run();
    @(posedge mclk);
    wait_instruction <= 1'b1;
    @(posedge mclk);
    wait_instruction <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("cpu_clk_en", 0, cpu_clk_en);
    phi_rate(50);
    periph_irq <= 1'b1;
    for (i = 0; i < 10 && wake_service !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    chk("wake_service", 1, wake_service);
    @(posedge mclk);
    periph_irq <= 1'b0;
    #1;
    chk("cpu_clk_en", 1, cpu_clk_en);
    stop_run();
    stop_test();
  end
endmodule // tb_clock_synth_power_reset
